// >>> inc/drtal_cfg.svh
// Offsets, field positions, reset values and timing counts of the alarm block.
`ifndef DRTAL_CFG_SVH
`define DRTAL_CFG_SVH

// Widths and channel count.
`define DRTAL_NCH 2
`define DRTAL_RATE_W 20
`define DRTAL_VAL_W 27
`define DRTAL_SEC_W 12
`define DRTAL_CODE_W 16
`define DRTAL_ADDR_W 8

// Timing: clock rate in MHz and the total compare interval in ms.
`define DRTAL_CLK_MHZ 200
`define DRTAL_HALF_SEC_MS 500
`define DRTAL_HALF_SEC_CYC (`DRTAL_HALF_SEC_MS * 1000 * `DRTAL_CLK_MHZ)

// Limits: 3600 s, rate 999999, total 99999999.
`define DRTAL_MAX_SEC 32'h00000E10
`define DRTAL_RATE_SP_MAX 32'h000F423F
`define DRTAL_TOTAL_SP_MAX 32'h05F5E0FF

// Register offsets; channel two sits one stride above channel one.
`define DRTAL_CH_STRIDE 8'h20
`define DRTAL_OFS_CTRL 8'h00
`define DRTAL_OFS_SP 8'h04
`define DRTAL_OFS_HYST 8'h08
`define DRTAL_OFS_DLY 8'h0C
`define DRTAL_OFS_SIL 8'h10
`define DRTAL_OFS_ACC 8'h40
`define DRTAL_OFS_STAT 8'h44

// Control fields.
`define DRTAL_CTRL_EN 0
`define DRTAL_CTRL_SRC 1
`define DRTAL_CTRL_SENSE 2
`define DRTAL_CTRL_NC 3

// Access register fields.
`define DRTAL_ACC_EN 0
`define DRTAL_ACC_CODE_LSB 4

// Status: eight bits per channel.
`define DRTAL_STAT_STRIDE 8
`define DRTAL_STAT_COND 0
`define DRTAL_STAT_ALARM 1
`define DRTAL_STAT_OUT 2
`define DRTAL_STAT_IND 3
`define DRTAL_STAT_ST_LSB 4

// Reset values.
`define DRTAL_RST_EN 1'b0
`define DRTAL_RST_SRC 1'b0
`define DRTAL_RST_SENSE 1'b0
`define DRTAL_RST_NC 1'b0
`define DRTAL_RST_SP 27'h0000000
`define DRTAL_RST_HYST 20'h00000
`define DRTAL_RST_SEC 12'h000
`define DRTAL_RST_ACC_EN 1'b0
`define DRTAL_RST_CODE 16'h0000

`endif

// >>> inc/drtal_pkg.sv
// Types shared by the alarm block modules.
`include "drtal_cfg.svh"
package drtal_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_DELAY = 4'h2,
      ST_ACTIVE = 4'h4,
      ST_SILENCE = 4'h8
   } drtal_state_t;

   typedef struct packed {
      logic en;
      logic src;
      logic sense;
      logic nc;
      logic [`DRTAL_VAL_W-1:0] sp;
      logic [`DRTAL_RATE_W-1:0] hyst;
      logic [`DRTAL_SEC_W-1:0] dly;
      logic [`DRTAL_SEC_W-1:0] silence_duration;
   } drtal_ccfg_t;

   typedef struct packed {
      drtal_state_t st;
      logic cond;
      logic [`DRTAL_SEC_W-1:0] cnt;
      logic out;
      logic ind;
   } drtal_cst_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic half;
      logic sec;
      logic flash;
   } drtal_tick_t;

   typedef struct packed {
      drtal_ccfg_t [`DRTAL_NCH-1:0] cfg;
      logic [`DRTAL_VAL_W-1:0] total;
      logic acc_en;
      logic [`DRTAL_CODE_W-1:0] acc_code;
      logic [31:0] rdata;
      logic ack;
   } drtal_top_t;

endpackage

// >>> inc/drtal_chan_if.sv
// Carrier between the register file and one alarm channel.
`timescale 1ns/1ps
`include "drtal_cfg.svh"
interface drtal_chan_if;
   drtal_pkg::drtal_ccfg_t cfg;
   logic [`DRTAL_RATE_W-1:0] rate;
   logic [`DRTAL_VAL_W-1:0] total;
   logic sec_tick;
   logic flash;
   logic accept;
   logic cond;
   logic out;
   logic ind;
   drtal_pkg::drtal_state_t st;

   modport ctl (output cfg, rate, total, sec_tick, flash, accept,
                input cond, out, ind, st);
   modport chan (input cfg, rate, total, sec_tick, flash, accept,
                 output cond, out, ind, st);
endinterface

// >>> rtl/drtal_tick.sv
// Half-second and one-second tick generator with indicator flash phase.
`timescale 1ns/1ps
`include "drtal_cfg.svh"
module drtal_tick #(
   parameter int unsigned HALF_CYC = `DRTAL_HALF_SEC_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   output logic half_tick,
   output logic sec_tick,
   output logic flash
);
   drtal_pkg::drtal_tick_t s_q;
   drtal_pkg::drtal_tick_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.half = 1'b0;
      s_d.sec = 1'b0;
      if (s_q.cnt == 32'(HALF_CYC - 1))
      begin
         s_d.cnt = 32'h00000000;
         s_d.half = 1'b1;
         s_d.flash = ~s_q.flash;
         // Every second half-second closes a full second.
         s_d.sec = s_q.flash;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign half_tick = s_q.half;
   assign sec_tick = s_q.sec;
   assign flash = s_q.flash;
endmodule

// >>> rtl/drtal_chan.sv
// One alarm channel: compare, hysteresis, delay, silence and output drive.
`timescale 1ns/1ps
`include "drtal_cfg.svh"
module drtal_chan (
   input wire logic core_clk,
   input wire logic rst,
   drtal_chan_if.chan ch
);
   drtal_pkg::drtal_cst_t s_q;
   drtal_pkg::drtal_cst_t s_d;
   logic [`DRTAL_VAL_W:0] val;
   logic [`DRTAL_VAL_W:0] sp;
   logic [`DRTAL_VAL_W:0] hy;
   logic cond;
   logic alarm;

   always_comb
   begin
      val = ch.cfg.src ? {1'b0, ch.total} : (`DRTAL_VAL_W+1)'(ch.rate);
      sp = {1'b0, ch.cfg.sp};
      // Total channels compare without any hysteresis band.
      hy = ch.cfg.src ? '0 : (`DRTAL_VAL_W+1)'(ch.cfg.hyst);
      if (!ch.cfg.sense)
      begin
         // High sense: trip at or above, release below setpoint minus band.
         cond = s_q.cond ? !(val + hy < sp) : (val >= sp);
      end
      else
      begin
         // Low sense mirrors the high sense.
         cond = s_q.cond ? !(val > sp + hy) : (val <= sp);
      end
      s_d = s_q;
      s_d.cond = cond & ch.cfg.en;
      if (!s_d.cond)
      begin
         s_d.st = drtal_pkg::ST_IDLE;
         s_d.cnt = '0;
      end
      else
      begin
         unique case (s_q.st)
            drtal_pkg::ST_IDLE:
            begin
               s_d.cnt = '0;
               s_d.st = (ch.cfg.dly == '0) ? drtal_pkg::ST_ACTIVE : drtal_pkg::ST_DELAY;
            end
            drtal_pkg::ST_DELAY:
            begin
               if (ch.sec_tick)
               begin
                  s_d.cnt = s_q.cnt + 1'b1;
                  if (s_q.cnt + 1'b1 >= ch.cfg.dly)
                  begin
                     s_d.st = drtal_pkg::ST_ACTIVE;
                  end
               end
            end
            drtal_pkg::ST_ACTIVE:
            begin
               if (ch.accept && ch.cfg.silence_duration != '0)
               begin
                  s_d.st = drtal_pkg::ST_SILENCE;
                  s_d.cnt = '0;
               end
            end
            drtal_pkg::ST_SILENCE:
            begin
               if (ch.sec_tick)
               begin
                  s_d.cnt = s_q.cnt + 1'b1;
                  if (s_q.cnt + 1'b1 >= ch.cfg.silence_duration)
                  begin
                     s_d.st = drtal_pkg::ST_ACTIVE;
                  end
               end
            end
            default:
            begin
               s_d.st = drtal_pkg::ST_IDLE;
            end
         endcase
      end
      alarm = (s_d.st == drtal_pkg::ST_ACTIVE);
      // A high output means the switch is closed.
      s_d.out = alarm ^ ch.cfg.nc;
      s_d.ind = alarm | ((s_d.st != drtal_pkg::ST_IDLE) & ch.flash);
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '{st: drtal_pkg::ST_IDLE, default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign ch.cond = s_q.cond;
   assign ch.out = s_q.out;
   assign ch.ind = s_q.ind;
   assign ch.st = s_q.st;
endmodule

// >>> rtl/drtal_top.sv
// Two-channel rate and total alarm block with its register file.
//
// What this block does
// - Two channels, sense, source, polarity each independent.
// - Each channel picks rate or total freely.
// - Total sampled and compared twice per second.
// - Alarm trips when value reaches setpoint.
// - Hysteresis only on rate-source channels.
// - Polarity picks switch state without alarm.
// - Output activates only after programmed delay.
// - Accepted alarm silenced for programmed duration.
// - Indicator flashes in delay or silence.
// - Enable bit gates alarm, keeps parameters.
// - Recalibration clears both enable bits.
// - Source change restores defaults, clears enable.
// - Direct setpoint access behind separate code.
// - Delay zero to 3600 seconds.
// - Nonzero silence makes P an accept.
// - High rate alarm releases below setpoint minus hysteresis.
// - Rate setpoint to 999999, total 99999999.
`timescale 1ns/1ps
`include "drtal_cfg.svh"
module drtal_top #(
   parameter int unsigned HALF_SEC_CYC = `DRTAL_HALF_SEC_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [`DRTAL_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [`DRTAL_RATE_W-1:0] rate_value,
   input wire logic [`DRTAL_VAL_W-1:0] total_value,
   input wire logic accept_btn,
   input wire logic recal_pulse,
   input wire logic dsp_sp_wr,
   input wire logic dsp_sp_sel,
   input wire logic [`DRTAL_VAL_W-1:0] dsp_sp_data,
   input wire logic [`DRTAL_CODE_W-1:0] dsp_code,
   output logic dsp_sp_ack,
   output logic [`DRTAL_NCH-1:0] alarm_out,
   output logic [`DRTAL_NCH-1:0] alarm_ind
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Setpoints are held in range for the channel's source.
   function automatic logic [`DRTAL_VAL_W-1:0] sp_clamp(input logic src, input logic [31:0] d);
      logic [31:0] lim;
      lim = src ? `DRTAL_TOTAL_SP_MAX : `DRTAL_RATE_SP_MAX;
      sp_clamp = (d > lim) ? `DRTAL_VAL_W'(lim) : `DRTAL_VAL_W'(d);
   endfunction

   function automatic logic [`DRTAL_SEC_W-1:0] sec_clamp(input logic [31:0] d);
      sec_clamp = (d > `DRTAL_MAX_SEC) ? `DRTAL_SEC_W'(`DRTAL_MAX_SEC) : `DRTAL_SEC_W'(d);
   endfunction

   localparam drtal_pkg::drtal_ccfg_t CFG_RST = '{
      en: `DRTAL_RST_EN,
      src: `DRTAL_RST_SRC,
      sense: `DRTAL_RST_SENSE,
      nc: `DRTAL_RST_NC,
      sp: `DRTAL_RST_SP,
      hyst: `DRTAL_RST_HYST,
      dly: `DRTAL_RST_SEC,
      silence_duration: `DRTAL_RST_SEC
   };

   ////////////////////////////////////////////////////////////////////////////////////////
   // Ticks and channels.

   logic half_tick;
   logic sec_tick;
   logic flash;

   drtal_tick #(
      .HALF_CYC(HALF_SEC_CYC)
   ) u_tick (
      .core_clk(core_clk),
      .rst(rst),
      .half_tick(half_tick),
      .sec_tick(sec_tick),
      .flash(flash)
   );

   drtal_pkg::drtal_top_t s_q;
   drtal_pkg::drtal_top_t s_d;

   drtal_chan_if chif[`DRTAL_NCH]();

   logic [`DRTAL_NCH-1:0] ch_cond;
   logic [`DRTAL_NCH-1:0] ch_out;
   logic [`DRTAL_NCH-1:0] ch_ind;
   drtal_pkg::drtal_state_t [`DRTAL_NCH-1:0] ch_st;

   for (genvar g = 0; g < `DRTAL_NCH; g++)
   begin : g_ch
      assign chif[g].cfg = s_q.cfg[g];
      assign chif[g].rate = rate_value;
      assign chif[g].total = s_q.total;
      assign chif[g].sec_tick = sec_tick;
      assign chif[g].flash = flash;
      assign chif[g].accept = accept_btn;
      assign ch_cond[g] = chif[g].cond;
      assign ch_out[g] = chif[g].out;
      assign ch_ind[g] = chif[g].ind;
      assign ch_st[g] = chif[g].st;

      drtal_chan u_chan (
         .core_clk(core_clk),
         .rst(rst),
         .ch(chif[g].chan)
      );
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register file, direct access and total sampling.

   logic code_ok;
   logic [`DRTAL_ADDR_W-1:0] cb;
   logic [31:0] stat;

   always_comb
   begin
      s_d = s_q;
      s_d.rdata = 32'h00000000;
      s_d.ack = 1'b0;
      cb = '0;
      stat = 32'h00000000;

      // The total is only refreshed on the half-second tick.
      if (half_tick)
      begin
         s_d.total = total_value;
      end

      // Operator setpoint path; a code of zero means no code is asked for.
      code_ok = (s_q.acc_code == '0) || (dsp_code == s_q.acc_code);
      if (dsp_sp_wr && s_q.acc_en && code_ok)
      begin
         s_d.cfg[dsp_sp_sel].sp = sp_clamp(s_q.cfg[dsp_sp_sel].src,
                                           32'(dsp_sp_data));
         s_d.ack = 1'b1;
      end

      // Bus writes come after the operator path, so software wins a tie.
      if (reg_wr)
      begin
         for (int i = 0; i < `DRTAL_NCH; i++)
         begin
            cb = `DRTAL_ADDR_W'(i * `DRTAL_CH_STRIDE);
            if (reg_addr == cb + `DRTAL_OFS_CTRL)
            begin
               if (reg_wdata[`DRTAL_CTRL_SRC] != s_q.cfg[i].src)
               begin
                  s_d.cfg[i] = CFG_RST;
                  s_d.cfg[i].src = reg_wdata[`DRTAL_CTRL_SRC];
               end
               else
               begin
                  s_d.cfg[i].en = reg_wdata[`DRTAL_CTRL_EN];
                  s_d.cfg[i].sense = reg_wdata[`DRTAL_CTRL_SENSE];
                  s_d.cfg[i].nc = reg_wdata[`DRTAL_CTRL_NC];
               end
            end
            if (reg_addr == cb + `DRTAL_OFS_SP)
            begin
               s_d.cfg[i].sp = sp_clamp(s_q.cfg[i].src, reg_wdata);
            end
            if (reg_addr == cb + `DRTAL_OFS_HYST && !s_q.cfg[i].src)
            begin
               s_d.cfg[i].hyst = reg_wdata[`DRTAL_RATE_W-1:0];
            end
            if (reg_addr == cb + `DRTAL_OFS_DLY)
            begin
               s_d.cfg[i].dly = sec_clamp(reg_wdata);
            end
            if (reg_addr == cb + `DRTAL_OFS_SIL)
            begin
               s_d.cfg[i].silence_duration = sec_clamp(reg_wdata);
            end
         end
         if (reg_addr == `DRTAL_OFS_ACC)
         begin
            s_d.acc_en = reg_wdata[`DRTAL_ACC_EN];
            s_d.acc_code = reg_wdata[`DRTAL_ACC_CODE_LSB +: `DRTAL_CODE_W];
         end
      end

      // Recalibration overrides any enable written in the same cycle.
      if (recal_pulse)
      begin
         for (int i = 0; i < `DRTAL_NCH; i++)
         begin
            s_d.cfg[i].en = 1'b0;
         end
      end

      for (int i = 0; i < `DRTAL_NCH; i++)
      begin
         stat[i*`DRTAL_STAT_STRIDE + `DRTAL_STAT_COND] = ch_cond[i];
         stat[i*`DRTAL_STAT_STRIDE + `DRTAL_STAT_ALARM] = (ch_st[i] == drtal_pkg::ST_ACTIVE);
         stat[i*`DRTAL_STAT_STRIDE + `DRTAL_STAT_OUT] = ch_out[i];
         stat[i*`DRTAL_STAT_STRIDE + `DRTAL_STAT_IND] = ch_ind[i];
         stat[i*`DRTAL_STAT_STRIDE + `DRTAL_STAT_ST_LSB +: 4] = ch_st[i];
      end

      // Reads answer in the next cycle; unmapped offsets read zero.
      if (reg_rd)
      begin
         for (int i = 0; i < `DRTAL_NCH; i++)
         begin
            cb = `DRTAL_ADDR_W'(i * `DRTAL_CH_STRIDE);
            if (reg_addr == cb + `DRTAL_OFS_CTRL)
            begin
               s_d.rdata[`DRTAL_CTRL_EN] = s_q.cfg[i].en;
               s_d.rdata[`DRTAL_CTRL_SRC] = s_q.cfg[i].src;
               s_d.rdata[`DRTAL_CTRL_SENSE] = s_q.cfg[i].sense;
               s_d.rdata[`DRTAL_CTRL_NC] = s_q.cfg[i].nc;
            end
            if (reg_addr == cb + `DRTAL_OFS_SP)
            begin
               s_d.rdata = 32'(s_q.cfg[i].sp);
            end
            if (reg_addr == cb + `DRTAL_OFS_HYST)
            begin
               s_d.rdata = s_q.cfg[i].src ? 32'h00000000 : 32'(s_q.cfg[i].hyst);
            end
            if (reg_addr == cb + `DRTAL_OFS_DLY)
            begin
               s_d.rdata = 32'(s_q.cfg[i].dly);
            end
            if (reg_addr == cb + `DRTAL_OFS_SIL)
            begin
               s_d.rdata = 32'(s_q.cfg[i].silence_duration);
            end
         end
         if (reg_addr == `DRTAL_OFS_ACC)
         begin
            s_d.rdata[`DRTAL_ACC_EN] = s_q.acc_en;
            s_d.rdata[`DRTAL_ACC_CODE_LSB +: `DRTAL_CODE_W] = s_q.acc_code;
         end
         if (reg_addr == `DRTAL_OFS_STAT)
         begin
            s_d.rdata = stat;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_q.cfg <= {`DRTAL_NCH{CFG_RST}};
         s_q.total <= `DRTAL_RST_SP;
         s_q.acc_en <= `DRTAL_RST_ACC_EN;
         s_q.acc_code <= `DRTAL_RST_CODE;
         s_q.rdata <= 32'h00000000;
         s_q.ack <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign reg_rdata = s_q.rdata;
   assign dsp_sp_ack = s_q.ack;
   assign alarm_out = ch_out;
   assign alarm_ind = ch_ind;

endmodule

// >>> dv/drtal_load_model.sv
// Switched dc loads hanging on the two alarm switch outputs.
`timescale 1ns/1ps
module drtal_load_model (
   input wire logic [1:0] sw_closed,
   output logic [1:0] load_on
);
   // Current flows only through a closed switch; an open one leaves the load dead.
   assign load_on = sw_closed;
endmodule

// >>> dv/drtal_top_assertions.sv
// Port-level concurrent checks of the two-channel alarm block.
`timescale 1ns/1ps
`include "drtal_cfg.svh"
module drtal_top_assertions (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [`DRTAL_ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic recal_pulse,
   input wire logic dsp_sp_wr,
   input wire logic dsp_sp_ack,
   input wire logic [`DRTAL_NCH-1:0] alarm_out,
   input wire logic [`DRTAL_NCH-1:0] alarm_ind
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
      else $error("read data not zero outside a read");
   chk_unmapped_read: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_ack_cause: assert property (dsp_sp_ack |-> $past(dsp_sp_wr))
      else $error("setpoint ack without a request");
   chk_rst_quiet: assert property ($past(rst) |-> alarm_out == 2'h0 && alarm_ind == 2'h0)
      else $error("outputs not idle after reset");
   chk_recal_quiet: assert property (recal_pulse |-> ##[1:3] alarm_ind == 2'h0)
      else $error("indicators still lit after recalibration");
   chk_stat_onehot: assert property (reg_rd && reg_addr == 8'h44 |=>
      $onehot(reg_rdata[7:4]) && $onehot(reg_rdata[15:12]))
      else $error("channel state not one-hot");
   chk_stat_out: assert property (reg_rd && reg_addr == 8'h44 |=>
      reg_rdata[2] == $past(alarm_out[0]) && reg_rdata[10] == $past(alarm_out[1]))
      else $error("status out bits differ from switch outputs");
   chk_stat_ind: assert property (reg_rd && reg_addr == 8'h44 |=>
      reg_rdata[3] == $past(alarm_ind[0]) && reg_rdata[11] == $past(alarm_ind[1]))
      else $error("status ind bits differ from indicators");
endmodule

// >>> dv/test_dual_rate_total_alarm_logic.sv
// Register-level tests of the two-channel alarm block with its loads.
`timescale 1ns/1ps
`include "drtal_cfg.svh"
module test_dual_rate_total_alarm_logic;
   logic core_clk, rst, reg_wr, reg_rd, accept_btn, recal_pulse;
   logic dsp_sp_wr, dsp_sp_sel, dsp_sp_ack;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [19:0] rate_value;
   logic [26:0] total_value, dsp_sp_data;
   logic [15:0] dsp_code;
   logic [1:0] alarm_out, alarm_ind, load_on, ind_seen;
   int error_cnt, compares, n;

   drtal_top #(.HALF_SEC_CYC(20)) DUT (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rate_value(rate_value), .total_value(total_value),
      .accept_btn(accept_btn), .recal_pulse(recal_pulse), .dsp_sp_wr(dsp_sp_wr),
      .dsp_sp_sel(dsp_sp_sel), .dsp_sp_data(dsp_sp_data), .dsp_code(dsp_code),
      .dsp_sp_ack(dsp_sp_ack), .alarm_out(alarm_out), .alarm_ind(alarm_ind));
   drtal_load_model u_load (.sw_closed(alarm_out), .load_on(load_on));

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      // One idle edge keeps a following write from re-raising the strobe in this step.
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
      @(posedge core_clk);
   endtask

   // Changes the rate, lets the pipeline settle, then checks switch, lamp and load of ch1.
   task automatic settle(input logic [19:0] r, input logic eo, input logic ei);
      rate_value <= r;
      repeat (4) @(posedge core_clk);
      #1 chk({alarm_out[0], alarm_ind[0], load_on[0]}, {eo, ei, eo});
      @(posedge core_clk);
   endtask

   // Waits for a switch output to reach a level, recording indicator levels seen.
   task automatic wait_out(input int c, input logic v, input int b);
      n = 0;
      ind_seen = 2'h0;
      while (alarm_out[c] !== v && n < b)
      begin
         @(posedge core_clk);
         #1 ind_seen[alarm_ind[c]] = 1'b1;
         n++;
      end
      if (n >= b)
      begin
         error_cnt++;
         $display("ERROR t=%0t wait ran out got=%h exp=%h", $time, alarm_out[c], v);
         close_out();
      end
      else
      begin
         @(posedge core_clk);
      end
   endtask

   task automatic dsp(input logic s, input logic [15:0] code, input logic [26:0] d,
                      input logic ea);
      dsp_sp_sel <= s;
      dsp_sp_data <= d;
      dsp_code <= code;
      dsp_sp_wr <= 1'b1;
      @(posedge core_clk);
      dsp_sp_wr <= 1'b0;
      #1 chk(dsp_sp_ack, ea);
      @(posedge core_clk);
   endtask

   initial
   begin
      {rst, reg_wr, reg_rd, accept_btn, recal_pulse, dsp_sp_wr, dsp_sp_sel} = 7'h01 << 6;
      {reg_addr, reg_wdata, rate_value, total_value, dsp_sp_data, dsp_code} = '0;
      error_cnt = 0;
      compares = 0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(8'h00, 32'h0);
      rd(8'h24, 32'h0);
      rd(8'h44, 32'h00001010);
      rd(8'hFC, 32'h0);
      $display("reset values done");
      wr(8'h24, 32'h0FFFFFFF);
      rd(8'h24, 32'h000F423F);
      wr(8'h2C, 32'h00000FFF);
      rd(8'h2C, 32'h00000E10);
      wr(8'h30, 32'h00000FFF);
      rd(8'h30, 32'h00000E10);
      wr(8'h28, 32'h00012345);
      rd(8'h28, 32'h00012345);
      wr(8'h20, 32'h0000000F);
      rd(8'h20, 32'h00000002);
      rd(8'h24, 32'h0);
      rd(8'h2C, 32'h0);
      rd(8'h30, 32'h0);
      rd(8'h28, 32'h0);
      wr(8'h28, 32'h00000055);
      rd(8'h28, 32'h0);
      wr(8'h24, 32'h07FFFFFF);
      rd(8'h24, 32'h05F5E0FF);
      $display("limits and type change done");
      wr(8'h04, 32'h00000064);
      wr(8'h08, 32'h0000000A);
      wr(8'h00, 32'h00000009);
      settle(20'h00063, 1'b1, 1'b0);
      settle(20'h00064, 1'b0, 1'b1);
      settle(20'h0005B, 1'b0, 1'b1);
      settle(20'h00059, 1'b1, 1'b0);
      wr(8'h00, 32'h0000000D);
      settle(20'h00064, 1'b0, 1'b1);
      settle(20'h00069, 1'b0, 1'b1);
      settle(20'h0006F, 1'b1, 1'b0);
      rd(8'h04, 32'h00000064);
      $display("sense and hysteresis done");
      rate_value <= 20'h0;
      wr(8'h00, 32'h00000001);
      wr(8'h0C, 32'h00000002);
      rate_value <= 20'h00064;
      repeat (4) @(posedge core_clk);
      rd(8'h44, 32'h00001021, 32'h0000FFF7);
      wait_out(0, 1'b1, 200);
      chk(n >= 35 && n <= 90, 1'b1);
      chk(ind_seen, 2'h3);
      wr(8'h10, 32'h00000001);
      accept_btn <= 1'b1;
      @(posedge core_clk);
      accept_btn <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk(alarm_out[0], 1'b0);
      wait_out(0, 1'b1, 60);
      chk(n <= 45, 1'b1);
      wr(8'h10, 32'h0);
      accept_btn <= 1'b1;
      @(posedge core_clk);
      accept_btn <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk(alarm_out[0], 1'b1);
      $display("delay and silence done");
      wr(8'h20, 32'h00000003);
      wr(8'h24, 32'h000003E8);
      total_value <= 27'h00003E8;
      wait_out(1, 1'b1, 30);
      chk(alarm_out, 2'h3);
      recal_pulse <= 1'b1;
      @(posedge core_clk);
      recal_pulse <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h20, 32'h00000002);
      $display("total and recalibration done");
      wr(8'h40, 32'h00012341);
      dsp(1'b1, 16'h1111, 27'h00001F4, 1'b0);
      rd(8'h24, 32'h000003E8);
      dsp(1'b1, 16'h1234, 27'h00001F4, 1'b1);
      rd(8'h24, 32'h000001F4);
      dsp(1'b0, 16'h1234, 27'h0FFFFFF, 1'b1);
      rd(8'h04, 32'h000F423F);
      wr(8'h40, 32'h00000001);
      dsp(1'b1, 16'h5555, 27'h0000010, 1'b1);
      rd(8'h24, 32'h00000010);
      wr(8'h40, 32'h0);
      dsp(1'b1, 16'h0000, 27'h0000020, 1'b0);
      rd(8'h24, 32'h00000010);
      $display("direct access done");
      close_out();
   end
endmodule

bind drtal_top drtal_top_assertions u_chk (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .recal_pulse(recal_pulse), .dsp_sp_wr(dsp_sp_wr), .dsp_sp_ack(dsp_sp_ack),
   .alarm_out(alarm_out), .alarm_ind(alarm_ind));
